// ==== sensor_status_data_regs_regs.vh ====
// Register offsets, field positions and reset values of the sensor status and data register bank.
`ifndef SENSOR_STATUS_DATA_REGS_REGS_VH
`define SENSOR_STATUS_DATA_REGS_REGS_VH
// Register indices; the byte address is four times the index.
`define IDX_PART_IDENTIFIER 8'h00
`define IDX_ERROR_REPORT 8'h02
`define IDX_SENSOR_STATUS 8'h03
`define IDX_AUX_X_LOW 8'h0a
`define IDX_AUX_X_HIGH 8'h0b
`define IDX_AUX_Y_LOW 8'h0c
`define IDX_AUX_Y_HIGH 8'h0d
`define IDX_AUX_Z_LOW 8'h0e
`define IDX_AUX_Z_HIGH 8'h0f
`define IDX_AUX_R_LOW 8'h10
`define IDX_AUX_R_HIGH 8'h11
`define IDX_ACCEL_X_LOW 8'h12
`define IDX_IRQ_STATUS 8'h20
`define IDX_IRQ_MASK 8'h21
// Error report fields.
`define ERR_FATAL_BIT 0
`define ERR_CMD_BIT 1
`define ERR_CODE_LSB 2
`define ERR_QOVF_BIT 6
`define ERR_SBUS_BIT 7
`define ERR_CODE_NONE 3'h0
`define ERR_CODE_ACCEL_SETUP 3'h1
`define ERROR_REPORT_RESET 8'h00
// Status fields.
`define STAT_MANUAL_OP_BIT 2
`define STAT_CMD_IDLE_BIT 4
`define STAT_AUX_READY_BIT 5
`define STAT_ACCEL_READY_BIT 7
`define SENSOR_STATUS_RESET 8'h10
// Interrupt status bits.
`define IRQ_AUX_READY_BIT 0
`define IRQ_ACCEL_READY_BIT 1
`define IRQ_QOVF_BIT 2
`define IRQ_SBUS_BIT 3
`define IRQ_FATAL_BIT 4
`define IRQ_WIDTH 5
`define IRQ_MASK_RESET 5'h00
// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== sensor_status_data_regs.v ====
// AXI4-Lite register bank with sensor identifier, error report, status and sample data.
`timescale 1ns/1ps
`include "sensor_status_data_regs_regs.vh"
module sensor_status_data_regs #(
  parameter [7:0] PART_ID = 8'h5c // Arbitrary value.
)(
  input wire aclk,
  input wire aresetn,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire fatal_fault_set,
  input wire cmd_fault_set,
  input wire accel_setup_invalid,
  input wire queue_overflow_set,
  input wire secondary_bus_fault_set,
  input wire command_busy,
  input wire secondary_manual_op,
  input wire aux_sample_valid,
  input wire [15:0] aux_x,
  input wire [15:0] aux_y,
  input wire [15:0] aux_z,
  input wire [15:0] aux_r,
  input wire accel_sample_valid,
  input wire [7:0] accel_x_low,
  output reg irq
);

  reg fatal_q, cmd_err_q, qovf_q, sbus_q;
  reg [2:0] fault_code_q;
  reg cmd_idle_q, manual_op_q, aux_ready_q, accel_ready_q;
  reg [15:0] aux_x_q, aux_y_q, aux_z_q, aux_r_q;
  reg [7:0] accel_x_q;
  reg [`IRQ_WIDTH-1:0] irq_stat_q, irq_mask_q;
  reg aw_held_q, w_held_q;
  reg [7:0] aw_idx_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [7:0] rd_idx;
  reg rd_fire;
  reg rd_addr_ok;
  reg [31:0] rd_word;
  reg rd_ok;
  reg wr_mapped;
  reg [7:0] error_report;
  reg [7:0] sensor_status;
  reg aux_read;
  reg accel_read;
  reg err_read;
  reg irq_read;
  reg [`IRQ_WIDTH-1:0] irq_events;
  reg [`IRQ_WIDTH-1:0] irq_stat_d;

  // Assemble the error report from its fields; the reserved bit stays zero.
  always @*
  begin
    error_report = `ERROR_REPORT_RESET;
    error_report[`ERR_FATAL_BIT] = fatal_q;
    error_report[`ERR_CMD_BIT] = cmd_err_q;
    error_report[`ERR_CODE_LSB +: 3] = fault_code_q;
    error_report[`ERR_QOVF_BIT] = qovf_q;
    error_report[`ERR_SBUS_BIT] = sbus_q;
  end

  // Assemble the status byte from its flags; reserved bits stay zero.
  always @*
  begin
    sensor_status = 8'h00;
    sensor_status[`STAT_MANUAL_OP_BIT] = manual_op_q;
    sensor_status[`STAT_CMD_IDLE_BIT] = cmd_idle_q;
    sensor_status[`STAT_AUX_READY_BIT] = aux_ready_q;
    sensor_status[`STAT_ACCEL_READY_BIT] = accel_ready_q;
  end

  // Read address handshake and the index and alignment of the address it carries.
  always @*
  begin
    rd_fire = s_axi_arvalid && s_axi_arready;
    rd_idx = s_axi_araddr[9:2];
    rd_addr_ok = s_axi_araddr[31:10] == 22'h000000 && s_axi_araddr[1:0] == 2'b00;
  end

  // Side effects of a read take place at the edge that takes its address.
  always @*
  begin
    aux_read = 1'b0;
    accel_read = 1'b0;
    err_read = 1'b0;
    irq_read = 1'b0;
    if (rd_fire && rd_addr_ok)
      case (rd_idx)
        `IDX_ERROR_REPORT: err_read = 1'b1;
        `IDX_AUX_X_LOW: aux_read = 1'b1;
        `IDX_AUX_X_HIGH: aux_read = 1'b1;
        `IDX_AUX_Y_LOW: aux_read = 1'b1;
        `IDX_AUX_Y_HIGH: aux_read = 1'b1;
        `IDX_AUX_Z_LOW: aux_read = 1'b1;
        `IDX_AUX_Z_HIGH: aux_read = 1'b1;
        `IDX_AUX_R_LOW: aux_read = 1'b1;
        `IDX_AUX_R_HIGH: aux_read = 1'b1;
        `IDX_ACCEL_X_LOW: accel_read = 1'b1;
        `IDX_IRQ_STATUS: irq_read = 1'b1;
        default: irq_read = 1'b0;
      endcase
  end

  // Read mux for every mapped register.
  always @*
  begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    if (!rd_addr_ok)
      rd_ok = 1'b0;
    else
      case (rd_idx)
        `IDX_PART_IDENTIFIER: rd_word = {24'h000000, PART_ID};
        `IDX_ERROR_REPORT: rd_word = {24'h000000, error_report};
        `IDX_SENSOR_STATUS: rd_word = {24'h000000, sensor_status};
        `IDX_AUX_X_LOW: rd_word = {24'h000000, aux_x_q[7:0]};
        `IDX_AUX_X_HIGH: rd_word = {24'h000000, aux_x_q[15:8]};
        `IDX_AUX_Y_LOW: rd_word = {24'h000000, aux_y_q[7:0]};
        `IDX_AUX_Y_HIGH: rd_word = {24'h000000, aux_y_q[15:8]};
        `IDX_AUX_Z_LOW: rd_word = {24'h000000, aux_z_q[7:0]};
        `IDX_AUX_Z_HIGH: rd_word = {24'h000000, aux_z_q[15:8]};
        `IDX_AUX_R_LOW: rd_word = {24'h000000, aux_r_q[7:0]};
        `IDX_AUX_R_HIGH: rd_word = {24'h000000, aux_r_q[15:8]};
        `IDX_ACCEL_X_LOW: rd_word = {24'h000000, accel_x_q};
        `IDX_IRQ_STATUS: rd_word = {27'h0000000, irq_stat_q};
        `IDX_IRQ_MASK: rd_word = {27'h0000000, irq_mask_q};
        default: rd_ok = 1'b0;
      endcase
  end

  // Read channel: one read at a time, answer one cycle after the address is taken.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
    else
      s_axi_arready <= 1'b1;
  end

  // Mapped indices answer a write with OKAY; only the mask takes its data.
  always @*
  begin
    wr_mapped = 1'b0;
    case (aw_idx_q)
      `IDX_PART_IDENTIFIER: wr_mapped = 1'b1;
      `IDX_ERROR_REPORT: wr_mapped = 1'b1;
      `IDX_SENSOR_STATUS: wr_mapped = 1'b1;
      `IDX_AUX_X_LOW: wr_mapped = 1'b1;
      `IDX_AUX_X_HIGH: wr_mapped = 1'b1;
      `IDX_AUX_Y_LOW: wr_mapped = 1'b1;
      `IDX_AUX_Y_HIGH: wr_mapped = 1'b1;
      `IDX_AUX_Z_LOW: wr_mapped = 1'b1;
      `IDX_AUX_Z_HIGH: wr_mapped = 1'b1;
      `IDX_AUX_R_LOW: wr_mapped = 1'b1;
      `IDX_AUX_R_HIGH: wr_mapped = 1'b1;
      `IDX_ACCEL_X_LOW: wr_mapped = 1'b1;
      `IDX_IRQ_STATUS: wr_mapped = 1'b1;
      `IDX_IRQ_MASK: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // Write channel: address and data taken in either order; only the mask is writable.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      irq_mask_q <= `IRQ_MASK_RESET;
    end
    else
    begin
      // Each channel is refused while its item is held or a response waits.
      s_axi_awready <= !aw_held_q && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        aw_idx_q <= (s_axi_awaddr[31:10] == 22'h000000 && s_axi_awaddr[1:0] == 2'b00)
          ? s_axi_awaddr[9:2] : 8'hff;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_held_q && w_held_q && !s_axi_bvalid)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // Read-only registers accept the write and ignore it.
        s_axi_bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        if (aw_idx_q == `IDX_IRQ_MASK && wstrb_q[0])
          irq_mask_q <= wdata_q[`IRQ_WIDTH-1:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Error report flags; a fault in the clearing cycle keeps its flag set.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fatal_q <= 1'b0;
      cmd_err_q <= 1'b0;
      qovf_q <= 1'b0;
      sbus_q <= 1'b0;
      fault_code_q <= `ERR_CODE_NONE;
    end
    else
    begin
      fatal_q <= fatal_q || fatal_fault_set;
      cmd_err_q <= cmd_fault_set || (cmd_err_q && !err_read);
      qovf_q <= queue_overflow_set || (qovf_q && !err_read);
      sbus_q <= secondary_bus_fault_set || (sbus_q && !err_read);
      fault_code_q <= accel_setup_invalid ? `ERR_CODE_ACCEL_SETUP : `ERR_CODE_NONE;
    end
  end

  // Status flags and sample capture; a new sample beats the read that clears.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmd_idle_q <= 1'b1;
      manual_op_q <= 1'b0;
      aux_ready_q <= 1'b0;
      accel_ready_q <= 1'b0;
      aux_x_q <= 16'h0000;
      aux_y_q <= 16'h0000;
      aux_z_q <= 16'h0000;
      aux_r_q <= 16'h0000;
      accel_x_q <= 8'h00;
    end
    else
    begin
      cmd_idle_q <= !command_busy;
      manual_op_q <= secondary_manual_op;
      aux_ready_q <= aux_sample_valid || (aux_ready_q && !aux_read);
      accel_ready_q <= accel_sample_valid || (accel_ready_q && !accel_read);
      // All four auxiliary words are captured together so that they stay coherent.
      if (aux_sample_valid)
      begin
        aux_x_q <= aux_x;
        aux_y_q <= aux_y;
        aux_z_q <= aux_z;
        aux_r_q <= aux_r;
      end
      if (accel_sample_valid)
        accel_x_q <= accel_x_low;
    end
  end

  // Interrupt events in their status bit positions, and the next sticky status.
  always @*
  begin
    irq_events = {`IRQ_WIDTH{1'b0}};
    irq_events[`IRQ_AUX_READY_BIT] = aux_sample_valid;
    irq_events[`IRQ_ACCEL_READY_BIT] = accel_sample_valid;
    irq_events[`IRQ_QOVF_BIT] = queue_overflow_set;
    irq_events[`IRQ_SBUS_BIT] = secondary_bus_fault_set;
    irq_events[`IRQ_FATAL_BIT] = fatal_fault_set;
    irq_stat_d = irq_events | (irq_read ? {`IRQ_WIDTH{1'b0}} : irq_stat_q);
  end

  // Sticky interrupt status, cleared by a read of it, gated by the mask.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= {`IRQ_WIDTH{1'b0}};
      irq <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq <= |(irq_stat_d & irq_mask_q);
    end
  end

endmodule

// ==== command_executor_model.sv ====
// Behavioural model of the sensor core that runs host commands.
`timescale 1ns/1ps
module command_executor_model #(
  parameter LEN = 20
)(
  input wire aclk,
  input wire start,
  output reg busy = 1'b0
);
  integer n = 0;
  // A start runs one command for LEN cycles; the bench starts only while idle.
  always @(posedge aclk)
  begin
    if (start)
      n <= LEN;
    else if (n > 0)
      n <= n - 1;
    busy <= start || n > 1;
  end
endmodule

// ==== sensor_status_data_regs_properties.sv ====
// Bus handshake and read-data properties of the sensor register bank.
`timescale 1ns/1ps
module sensor_status_data_regs_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire irq
);
  // All properties share the bus clock and its reset.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A taken read is answered next cycle with further reads refused.
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence r_held;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_read_answer: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered in one cycle");
  a_rdata_held: assert property (r_held |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_rresp_held: assert property (r_held |=> $stable(s_axi_rresp))
    else $error("read response changed while waiting");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_slverr_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 0)
    else $error("error response carries data");
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && !irq)
    else $error("outputs active after reset");
endmodule
bind sensor_status_data_regs sensor_status_data_regs_properties u_props (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .irq);

// ==== sensor_status_data_regs_tb.sv ====
// Self-checking bench for the sensor status and data register bank.
`timescale 1ns/1ps
`include "sensor_status_data_regs_regs.vh"
module sensor_status_data_regs_tb;
  localparam [7:0] PID = 8'h3b; // Arbitrary value.
  reg aclk = 0, aresetn = 0, start = 0, asi = 0, mop = 0;
  reg [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  reg s_axi_rready = 0;
  reg [5:0] ev = 0;
  reg [63:0] w = 64'hdef09abc56781234;
  reg [7:0] acc = 0, i;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, busy;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer n_mismatch = 0, n_checks = 0, cyc = 0;
  sensor_status_data_regs #(.PART_ID(PID)) uut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .fatal_fault_set(ev[0]), .cmd_fault_set(ev[1]), .accel_setup_invalid(asi),
    .queue_overflow_set(ev[2]), .secondary_bus_fault_set(ev[3]), .command_busy(busy),
    .secondary_manual_op(mop), .aux_sample_valid(ev[5]), .aux_x(w[15:0]), .aux_y(w[31:16]),
    .aux_z(w[47:32]), .aux_r(w[63:48]), .accel_sample_valid(ev[4]), .accel_x_low(acc), .irq);
  command_executor_model #(.LEN(20)) cmd (.aclk, .start, .busy);
  // The clock toggles every half period of 2.5 ns, and a hang is cut short.
  always #2.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  task test_done;
    begin
      if (n_mismatch == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e, input [127:0] m);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        $display("[FAIL] %0t %0s got %h", $time, m, g);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task rst;
    begin
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
    end
  endtask
  task pulse(input [5:0] v);
    begin
      ev <= v;
      @(posedge aclk);
      ev <= 6'h0;
    end
  endtask
  // A read holds its request until taken, and rready until the answer.
  task rd(input [7:0] a, input [7:0] e, input [1:0] r);
    begin
      s_axi_araddr <= {22'h0, a, 2'h0};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, {24'h0, e}, "read data");
      chk({30'h0, s_axi_rresp}, {30'h0, r}, "read response");
      @(posedge aclk);
    end
  endtask
  // A write offers address and data together and releases each when taken.
  task wr(input [7:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= {22'h0, a, 2'h0};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready === 1'b1)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1)
          s_axi_wvalid <= 1'b0;
      end while (s_axi_awvalid && s_axi_awready !== 1'b1 || s_axi_wvalid && s_axi_wready !== 1'b1);
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, 32'h0, "write response");
      @(posedge aclk);
    end
  endtask
  // Reset values, read-only writes, error flags, status, interrupts and data.
  initial
  begin
    rst;
    rd(`IDX_PART_IDENTIFIER, PID, 2'h0);
    rd(`IDX_ERROR_REPORT, 8'h00, 2'h0);
    rd(`IDX_SENSOR_STATUS, 8'h10, 2'h0);
    for (i = 8'h0a; i <= 8'h12; i = i + 8'h01) rd(i, 8'h00, 2'h0);
    wr(`IDX_PART_IDENTIFIER, 32'hff);
    wr(`IDX_SENSOR_STATUS, 32'hff);
    rd(`IDX_PART_IDENTIFIER, PID, 2'h0);
    rd(`IDX_SENSOR_STATUS, 8'h10, 2'h0);
    rd(8'h05, 8'h00, 2'h2);
    asi <= 1'b1;
    pulse(6'h0f);
    rd(`IDX_ERROR_REPORT, 8'hc7, 2'h0);
    rd(`IDX_ERROR_REPORT, 8'h05, 2'h0);
    asi <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(`IDX_ERROR_REPORT, 8'h01, 2'h0);
    rst;
    rd(`IDX_ERROR_REPORT, 8'h00, 2'h0);
    rd(`IDX_SENSOR_STATUS, 8'h10, 2'h0);
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    @(posedge aclk);
    rd(`IDX_SENSOR_STATUS, 8'h00, 2'h0);
    repeat (30) @(posedge aclk);
    mop <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`IDX_SENSOR_STATUS, 8'h14, 2'h0);
    mop <= 1'b0;
    wr(`IDX_IRQ_MASK, 32'h01);
    rd(`IDX_IRQ_MASK, 8'h01, 2'h0);
    acc <= 8'h5a;
    pulse(6'h10);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0, "masked irq");
    rd(`IDX_SENSOR_STATUS, 8'h90, 2'h0);
    pulse(6'h20);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd(`IDX_SENSOR_STATUS, 8'hb0, 2'h0);
    rd(`IDX_IRQ_STATUS, 8'h03, 2'h0);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(`IDX_AUX_X_LOW, 8'h34, 2'h0);
    rd(`IDX_SENSOR_STATUS, 8'h90, 2'h0);
    rd(`IDX_ACCEL_X_LOW, 8'h5a, 2'h0);
    rd(`IDX_SENSOR_STATUS, 8'h10, 2'h0);
    for (i = 0; i < 8; i = i + 8'h01) rd(8'h0a + i, w[8*i +: 8], 2'h0);
    test_done;
  end
endmodule
